// [rtl/stc_regs.svh]
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// How it works
// - Each threshold is 16 bits, low byte [7:0] and high byte [15:8], separately written.
// - Each axis X, Y, Z has two operate and two release thresholds, twelve total.
// - Thresholds are two's complement, same coding as measurement words.
// - Any threshold value is accepted; range and scale follow the measurement setting.
// - Writing 1 to bit 0 at index 30h resets every register.
// - The soft reset bit clears itself once the soft reset is done.
// - After reset the two-wire bus is enabled; lock register reads zero.
// - Writing 00011011 to the lock register disables the two-wire bus.
// - While disabled, writes of any other lock value are ignored.
// - Reset or eight consecutive start conditions re-enable the two-wire bus.

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define STC_IDX_SOFTWARE_RESET_CONTROL      8'h30
`define STC_IDX_LOCK      8'h31
`define STC_IDX_TEST_A    8'h40
`define STC_IDX_TEST_B    8'h41
`define STC_IDX_THR_BASE  8'h10
`define STC_IDX_THR_LAST  8'h27

// ----------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------
`define STC_THR_COUNT     12
`define STC_SOFTWARE_RESET_CONTROL_BIT      0
`define STC_SOFTWARE_RESET_CONTROL_RST      1'b0
`define STC_LOCK_RST      8'h00
`define STC_LOCK_KEY      8'h1B
`define STC_THR_RST       16'h0000
`define STC_START_RUN     4'h8

`endif

// [rtl/stc_pkg.sv]
package stc_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic signed [15:0] stc_thr_t;

    typedef enum logic [2:0]
    {
        STC_SEL_NONE = 3'b000,
        STC_SEL_THR  = 3'b001,
        STC_SEL_SOFTWARE_RESET_CONTROL = 3'b010,
        STC_SEL_LOCK = 3'b011,
        STC_SEL_TEST = 3'b100
    } stc_sel_e;

endpackage

// [rtl/stc_switch_regs.sv]
`include "stc_regs.svh"

module stc_switch_regs
#(
    parameter int          ADDR_W    = 12,
    parameter logic [3:0]  START_RUN = `STC_START_RUN
)
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         busStart,
    input  wire logic                         busOther,
    output logic                              busEnable,
    output logic                              softResetBusy,
    output logic [`STC_THR_COUNT*16-1:0]      thrLevels
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    stc_pkg::stc_thr_t  thr_r [`STC_THR_COUNT];
    logic               software_reset_control_r;
    logic [7:0]         lock_r;
    logic [3:0]         startCnt_r;
    logic [31:0]        prdata_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic         aligned;
    wire logic         upperZero;
    wire logic [7:0]   idx;
    wire logic         inThr;
    wire logic [7:0]   thrOff;
    wire logic [3:0]   thrNum;
    wire logic         thrHi;
    stc_pkg::stc_sel_e sel;
    wire logic         mapped;

    assign aligned   = (paddr[1:0] == 2'h0);
    assign upperZero = (paddr[ADDR_W-1:10] == '0);
    assign idx       = paddr[9:2];
    assign inThr     = (idx >= `STC_IDX_THR_BASE)
                    && (idx <= `STC_IDX_THR_LAST);
    assign thrOff    = idx - `STC_IDX_THR_BASE;
    assign thrNum    = inThr ? thrOff[4:1] : 4'h0;
    assign thrHi     = thrOff[0];

    assign sel = !(aligned && upperZero)   ? stc_pkg::STC_SEL_NONE :
                 inThr                     ? stc_pkg::STC_SEL_THR  :
                 (idx == `STC_IDX_SOFTWARE_RESET_CONTROL)    ? stc_pkg::STC_SEL_SOFTWARE_RESET_CONTROL :
                 (idx == `STC_IDX_LOCK)    ? stc_pkg::STC_SEL_LOCK :
                 (idx == `STC_IDX_TEST_A)  ? stc_pkg::STC_SEL_TEST :
                 (idx == `STC_IDX_TEST_B)  ? stc_pkg::STC_SEL_TEST :
                                             stc_pkg::STC_SEL_NONE;

    assign mapped = (sel != stc_pkg::STC_SEL_NONE);

    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    wire logic         setup;
    wire logic         access;
    wire logic         wrOk;
    wire logic [7:0]   wrByte;
    wire logic         wrThr;
    wire logic         wrSrst;
    wire logic         wrLock;
    wire logic         clearAll;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign wrOk     = access && pwrite && mapped && pstrb[0];
    assign wrByte   = pwdata[7:0];
    assign wrThr    = wrOk && (sel == stc_pkg::STC_SEL_THR);
    assign wrSrst   = wrOk && (sel == stc_pkg::STC_SEL_SOFTWARE_RESET_CONTROL);
    assign wrLock   = wrOk && (sel == stc_pkg::STC_SEL_LOCK);
    // Test words: writes are dropped and reads give zero
    assign clearAll = rst || software_reset_control_r;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_r;

    // ------------------------------------------------------------
    // Threshold storage
    // ------------------------------------------------------------
    wire logic [15:0]  curThr;
    wire logic [7:0]   curLo;
    wire logic [7:0]   curHi;
    wire logic         thrAnySet;
    logic [`STC_THR_COUNT-1:0] thrNz;

    assign curThr = thr_r[thrNum];
    assign curLo  = curThr[7:0];
    assign curHi  = curThr[15:8];

    genvar g;
    generate
        for (g = 0; g < `STC_THR_COUNT; g++)
        begin : gThr
            wire logic hit;
            assign hit = wrThr && (thrNum == 4'(g));

            always_ff @(posedge clk)
            begin
                if (clearAll)
                    thr_r[g] <= `STC_THR_RST;
                else if (hit && thrHi)
                    thr_r[g][15:8] <= wrByte;
                else if (hit)
                    thr_r[g][7:0] <= wrByte;
            end

            // Raw two's complement; no clamp or scale applied
            assign thrLevels[g*16 +: 16] = thr_r[g];
            assign thrNz[g] = (thr_r[g] != `STC_THR_RST);
        end
    endgenerate
    // Order per axis X, Y, Z: operate 1, release 1, operate 2, release 2

    assign thrAnySet = |thrNz;

    // ------------------------------------------------------------
    // Soft reset
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (clearAll)
            software_reset_control_r <= `STC_SOFTWARE_RESET_CONTROL_RST;
        else if (wrSrst && wrByte[`STC_SOFTWARE_RESET_CONTROL_BIT])
            software_reset_control_r <= 1'b1;
    end

    assign softResetBusy = software_reset_control_r;

    // ------------------------------------------------------------
    // Two-wire bus lock
    // ------------------------------------------------------------
    wire logic         busDisabled;
    wire logic         recover;
    wire logic [3:0]   startCnt_nxt;

    assign busDisabled  = (lock_r == `STC_LOCK_KEY);
    assign busEnable    = !busDisabled;
    assign recover      = busDisabled && busStart
                       && (startCnt_r == START_RUN - 4'h1);
    assign startCnt_nxt = !busDisabled ? 4'h0 :
                          busOther     ? 4'h0 :
                          recover      ? 4'h0 :
                          busStart     ? startCnt_r + 4'h1 :
                                         startCnt_r;

    always_ff @(posedge clk)
    begin
        if (clearAll)
            lock_r <= `STC_LOCK_RST;
        else if (recover)
            lock_r <= `STC_LOCK_RST;
        else if (wrLock && !busDisabled)
            lock_r <= wrByte;
    end

    always_ff @(posedge clk)
    begin
        if (clearAll)
            startCnt_r <= 4'h0;
        else
            startCnt_r <= startCnt_nxt;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rdByte;

    always_comb
    begin
        rdByte = 8'h00;
        case (sel)
            stc_pkg::STC_SEL_THR:  rdByte = thrHi ? curHi : curLo;
            stc_pkg::STC_SEL_SOFTWARE_RESET_CONTROL: rdByte = {7'h00, software_reset_control_r};
            stc_pkg::STC_SEL_LOCK: rdByte = lock_r;
            stc_pkg::STC_SEL_TEST: rdByte = 8'h00;
            default:               rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            prdata_r <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata_r <= {24'h00_0000, rdByte};
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_thr_lo;
        (wrThr && !software_reset_control_r && !thrHi)
        |=> (thr_r[$past(thrNum)][7:0] == $past(wrByte))
         && (thr_r[$past(thrNum)][15:8] == $past(curHi));
    endproperty
    a_thr_lo: assert property (p_thr_lo)
        else $error("threshold low byte write wrong");

    property p_thr_hi;
        (wrThr && !software_reset_control_r && thrHi)
        |=> (thr_r[$past(thrNum)][15:8] == $past(wrByte))
         && (thr_r[$past(thrNum)][7:0] == $past(curLo));
    endproperty
    a_thr_hi: assert property (p_thr_hi)
        else $error("threshold high byte write wrong");

    property p_thr_read;
        (setup && !pwrite && sel == stc_pkg::STC_SEL_THR)
        |=> (prdata == {24'h00_0000, $past(rdByte)});
    endproperty
    a_thr_read: assert property (p_thr_read)
        else $error("threshold read data wrong");

    property p_software_reset_control_all;
        (wrSrst && wrByte[`STC_SOFTWARE_RESET_CONTROL_BIT] && !software_reset_control_r)
        |=> software_reset_control_r ##1 (!thrAnySet && lock_r == `STC_LOCK_RST);
    endproperty
    a_software_reset_control_all: assert property (p_software_reset_control_all)
        else $error("soft reset did not clear registers");

    property p_software_reset_control_self;
        software_reset_control_r |=> !software_reset_control_r;
    endproperty
    a_software_reset_control_self: assert property (p_software_reset_control_self)
        else $error("soft reset bit did not clear");

    property p_rst_enable;
        $fell(rst) |-> busEnable && (lock_r == `STC_LOCK_RST);
    endproperty
    a_rst_enable: assert property (p_rst_enable)
        else $error("bus not enabled after reset");

    property p_lock_set;
        (wrLock && !busDisabled && !software_reset_control_r && wrByte == `STC_LOCK_KEY)
        |=> !busEnable;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("lock key did not disable bus");

    property p_lock_hold;
        (busDisabled && wrLock && !recover && !software_reset_control_r)
        |=> busDisabled;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock changed while disabled");

    property p_start_run;
        (busDisabled && !software_reset_control_r && !busOther && busStart)
        [*8] |=> busEnable;
    endproperty
    a_start_run: assert property (p_start_run)
        else $error("eight starts did not re-enable bus");

    property p_software_reset_control_unlock;
        software_reset_control_r |=> busEnable && (startCnt_r == 4'h0);
    endproperty
    a_software_reset_control_unlock: assert property (p_software_reset_control_unlock)
        else $error("soft reset left bus disabled");

endmodule

// [tb/stc_bus_model.sv]
module stc_bus_model
(
    input  wire logic clk,
    output logic      busStart,
    output logic      busOther
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Two-wire bus events, prompt or slow
    // ------------------------------------------------------------
    initial
    begin
        busStart = 1'b0;
        busOther = 1'b0;
    end

    task automatic starts(input int n, input int maxGap);
        int gap;
        repeat (n)
        begin
            gap = $urandom_range(0, maxGap);
            if (gap > 0)
            begin
                @(posedge clk) busStart <= 1'b0;
                repeat (gap - 1) @(posedge clk);
            end
            @(posedge clk) busStart <= 1'b1;
        end
        @(posedge clk) busStart <= 1'b0;
    endtask

    task automatic other();
        @(posedge clk) busOther <= 1'b1;
        @(posedge clk) busOther <= 1'b0;
    endtask
endmodule

// [tb/stc_switch_regs_tb.sv]
`include "stc_regs.svh"

module stc_switch_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] SOFT_RST_IDX = 8'h30;
    localparam logic [7:0] LOCK_IDX     = `STC_IDX_LOCK;

    logic         clk     = 1'b0;
    logic         rst     = 1'b1;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [11:0]  paddr   = 12'h000;
    logic [31:0]  pwdata  = 32'h0000_0000;
    logic [3:0]   pstrb   = 4'hF;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         busStart;
    logic         busOther;
    logic         busEnable;
    logic         softResetBusy;
    logic [191:0] thrLevels;
    int           mismatches = 0;
    int           checkCount = 0;
    logic [32:0]  expQ[$];
    logic [15:0]  thrExp[12];

    always #50 clk = ~clk;

    stc_switch_regs #(.ADDR_W(12), .START_RUN(`STC_START_RUN)) uut
    (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busStart(busStart), .busOther(busOther), .busEnable(busEnable),
        .softResetBusy(softResetBusy), .thrLevels(thrLevels)
    );

    stc_bus_model bm
    (
        .clk(clk), .busStart(busStart), .busOther(busOther)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] data, input logic [3:0] strb);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'($urandom()), data};
        pstrb   <= strb;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        apb(1'b1, idx, data, 4'hF);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
        expQ.push_back(exp);
        apb(1'b0, idx, 8'h00, 4'hF);
    endtask

    task automatic settle();
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Read watcher
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (psel && penable && pready && !pwrite)
        begin
            if (expQ.size() == 0)
            begin
                mismatches++;
                $display("MISMATCH at %0t: unexpected read", $time);
            end
            else
                check({pslverr, prdata}, expQ.pop_front());
        end
    end

    initial
    begin
        #(5000 * 100);
        mismatches++;
        $display("MISMATCH at %0t: timeout", $time);
        end_sim();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(28));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle();
        check(33'(busEnable), 33'h1);
        check(33'(|thrLevels), 33'h0);
        rd(LOCK_IDX, 33'h0);
        rd(SOFT_RST_IDX, 33'h0);
        for (int n = 0; n < 12; n++)
        begin
            thrExp[n] = (n == 0) ? 16'h8000 :
                        (n == 11) ? 16'h7FFF : 16'($urandom());
            wr(8'(`STC_IDX_THR_BASE + 2 * n), thrExp[n][7:0]);
            wr(8'(`STC_IDX_THR_BASE + 2 * n + 1), thrExp[n][15:8]);
        end
        apb(1'b1, `STC_IDX_THR_BASE, ~thrExp[0][7:0], 4'hE);
        for (int n = 0; n < 12; n++)
        begin
            rd(8'(`STC_IDX_THR_BASE + 2 * n), 33'(thrExp[n][7:0]));
            rd(8'(`STC_IDX_THR_BASE + 2 * n + 1), 33'(thrExp[n][15:8]));
            settle();
            check(33'(stc_pkg::stc_thr_t'(thrLevels[n*16+:16])),
                  33'($signed(thrExp[n])));
        end
        rd(8'h3F, {1'b1, 32'h0});
        wr(8'h3F, 8'h5A);
        rd(8'h28, {1'b1, 32'h0});
        rd(8'h3E, {1'b1, 32'h0});
        wr(LOCK_IDX, 8'h1A);
        settle();
        check(33'(busEnable), 33'h1);
        rd(LOCK_IDX, 33'h1A);
        wr(LOCK_IDX, `STC_LOCK_KEY);
        settle();
        check(33'(busEnable), 33'h0);
        wr(LOCK_IDX, 8'h00);
        rd(LOCK_IDX, 33'(`STC_LOCK_KEY));
        settle();
        check(33'(busEnable), 33'h0);
        bm.starts(7, 2);
        bm.other();
        bm.starts(7, 2);
        settle();
        check(33'(busEnable), 33'h0);
        bm.starts(1, 2);
        settle();
        check(33'(busEnable), 33'h1);
        rd(LOCK_IDX, 33'h0);
        wr(LOCK_IDX, `STC_LOCK_KEY);
        bm.starts(8, 0);
        settle();
        check(33'(busEnable), 33'h1);
        wr(LOCK_IDX, `STC_LOCK_KEY);
        wr(SOFT_RST_IDX, 8'h01);
        settle();
        check(33'(softResetBusy), 33'h1);
        settle();
        check(33'(softResetBusy), 33'h0);
        check(33'(|thrLevels), 33'h0);
        check(33'(busEnable), 33'h1);
        rd(SOFT_RST_IDX, 33'h0);
        rd(LOCK_IDX, 33'h0);
        wr(`STC_IDX_THR_BASE, 8'h77);
        wr(LOCK_IDX, `STC_LOCK_KEY);
        @(posedge clk) rst <= 1'b1;
        @(posedge clk);
        @(posedge clk) rst <= 1'b0;
        settle();
        check(33'(busEnable), 33'h1);
        check(33'(|thrLevels), 33'h0);
        end_sim();
    end
endmodule
